// ### logic/apc_pkg.sv
// constants, types and field layout of the converter prescale and clock source select registers
`default_nettype none
package apc_pkg;
	localparam int          APC_ADDR_W          = 8;
	localparam logic [7:0]  APC_OFS_DIVIDER     = 8'h2c;
	localparam logic [7:0]  APC_OFS_SOURCE      = 8'h30;
	localparam logic [31:0] APC_RESET_VALUE     = 32'h0000_0000;
	localparam int          APC_CONV_LSB        = 4;
	localparam int          APC_CONV_MSB        = 8;
	localparam int          APC_PLL_INPUT_PREDIVIDER_LSB      = 0;
	localparam int          APC_PLL_INPUT_PREDIVIDER_MSB      = 3;
	localparam int          APC_TIM_C_BIT       = 13;
	localparam int          APC_TIM_B_BIT       = 11;
	localparam int          APC_TIM_A_BIT       = 10;
	localparam int          APC_TIM_MAIN_BIT    = 8;
	localparam int          APC_I2C_A_BIT       = 4;
	localparam int          APC_I2C_B_BIT       = 5;
	localparam int          APC_I2C_C_BIT       = 6;
	localparam int          APC_SERIAL_LSB      = 0;
	localparam int          APC_SERIAL_MSB      = 1;
	localparam logic [4:0]  APC_TIM_MAX_DIV_LOG2 = 5'h01;
	localparam int          APC_RATIO_W         = 9;

	typedef enum logic [1:0] {
		APC_SRC_PERIPH_BUS,
		APC_SRC_SYSTEM_CORE,
		APC_SRC_EXT_SLOW,
		APC_SRC_INT_FAST
	} apc_serial_src_t;

	typedef struct packed {
		logic                  active;
		logic                  write;
		logic [APC_ADDR_W-1:0] addr;
		logic [3:0]            byte_en;
	} apc_ahb_state_t;

	typedef struct packed {
		logic [4:0]      conv_prescale;
		logic [3:0]      predivider;
		logic            timer_c;
		logic            timer_b;
		logic            timer_a;
		logic            timer_main;
		logic            i2c_a;
		logic            i2c_b;
		logic            i2c_c;
		apc_serial_src_t serial;
	} apc_cfg_state_t;
endpackage
`default_nettype wire

// ### logic/apc_regbus_if.sv
// register access carrier between the bus slave and the register file
`timescale 1ns/10ps
`default_nettype none
interface apc_regbus_if;
	logic                           wr_en;
	logic                           rd_en;
	logic [apc_pkg::APC_ADDR_W-1:0] addr;
	logic [3:0]                     byte_en;
	logic [31:0]                    wdata;
	logic [31:0]                    rdata;
	modport bridge (output wr_en, output rd_en, output addr, output byte_en, output wdata, input rdata);
	modport target (input wr_en, input rd_en, input addr, input byte_en, input wdata, output rdata);
endinterface
`default_nettype wire

// ### logic/apc_ahb_slave.sv
// zero wait state AHB-Lite slave front end
`timescale 1ns/10ps
`default_nettype none
module apc_ahb_slave
(
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// ahb-lite
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	// register side
	apc_regbus_if.bridge      bus
);
	apc_pkg::apc_ahb_state_t st;
	apc_pkg::apc_ahb_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.active = hsel && hready && htrans[1];
		next_st.write = hsel && hready && htrans[1] && hwrite;
		next_st.addr = {haddr[apc_pkg::APC_ADDR_W-1:2], 2'b00};
		unique case (hsize)
			3'h0: next_st.byte_en = 4'h1 << haddr[1:0];
			3'h1: next_st.byte_en = haddr[1] ? 4'hc : 4'h3;
			default: next_st.byte_en = 4'hf;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	// never stretches a data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = bus.rd_en ? bus.rdata : 32'h0000_0000;
	assign bus.wr_en = st.write;
	assign bus.rd_en = st.active && !st.write;
	assign bus.addr = st.addr;
	assign bus.byte_en = st.byte_en;
	assign bus.wdata = hwdata;
endmodule
`default_nettype wire

// ### logic/apc_tick_divider.sv
// divides a stream of source clock ticks by a programmable ratio
`timescale 1ns/10ps
`default_nettype none
module apc_tick_divider
#(
	parameter int WIDTH = 9
)
(
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// control
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] ratio,
	// ticks
	input  wire logic             tick_in,
	output logic                  tick_out
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             tick;
	} apc_div_state_t;

	apc_div_state_t st;
	apc_div_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!enable)
			next_st.count = '0;
		else if (tick_in)
		begin
			// ratio of one passes every tick
			if (st.count >= ratio - WIDTH'(1))
			begin
				next_st.count = '0;
				next_st.tick = 1'b1;
			end
			else
				next_st.count = st.count + WIDTH'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick_out = st.tick;
endmodule
`default_nettype wire

// ### logic/apc_clock_config.sv
// converter prescale, PLL predivider and peripheral clock source select registers
`timescale 1ns/10ps
`default_nettype none
module apc_clock_config
#(
	parameter bit HAS_I2C_PORT_C = 1'b1
)
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// clock tree status
	input  wire logic        pll_enabled,
	input  wire logic        system_core_clock_is_pll,
	input  wire logic [3:0]  ahb_divisor_log2,
	input  wire logic [2:0]  apb2_divisor_log2,
	// shared predivider bit seen from the main clock configuration register
	input  wire logic        main_cfg_bit17_wr,
	input  wire logic        main_cfg_bit17_wdata,
	output logic             main_cfg_bit17_rdata,
	// source clock ticks
	input  wire logic        pll_clock_tick,
	input  wire logic        external_fast_oscillator_tick,
	// converter clock
	output logic             converter_clock_enable,
	output logic [8:0]       converter_divide_ratio,
	output logic             converter_clock_tick,
	// pll reference
	output logic [4:0]       pll_input_divide_ratio,
	output logic             pll_reference_tick,
	// timer clock sources
	output logic             timer_a_clock_from_pll,
	output logic             timer_b_clock_from_pll,
	output logic             timer_c_clock_from_pll,
	output logic             main_timer_clock_from_pll,
	output logic             apb2_timer_clock_doubled,
	// i2c and serial clock sources
	output logic             i2c_port_a_clock_from_system,
	output logic             i2c_port_b_clock_from_system,
	output logic             i2c_port_c_clock_from_system,
	output logic [1:0]       serial_port_clock_source
);
	apc_regbus_if bus ();

	apc_pkg::apc_cfg_state_t st;
	apc_pkg::apc_cfg_state_t next_st;
	logic [31:0]             divider_word;
	logic [31:0]             source_word;
	logic [31:0]             byte_mask;
	logic [31:0]             merged;
	logic [4:0]              bus_div_log2;
	logic                    timer_group_open;
	logic                    main_timer_open;

	apc_ahb_slave u_slave
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.bus       (bus)
	);

	// prescale code to PLL division ratio
	function automatic logic [8:0] conv_ratio(input logic [3:0] code);
		logic [8:0] r;
		r = 9'h100;
		unique case (code)
			4'h0: r = 9'h001;
			4'h1: r = 9'h002;
			4'h2: r = 9'h004;
			4'h3: r = 9'h006;
			4'h4: r = 9'h008;
			4'h5: r = 9'h00a;
			4'h6: r = 9'h00c;
			4'h7: r = 9'h010;
			4'h8: r = 9'h020;
			4'h9: r = 9'h040;
			4'ha: r = 9'h080;
			default: r = 9'h100;
		endcase
		return r;
	endfunction

	// read-back images of the two registers
	always_comb
	begin
		divider_word = apc_pkg::APC_RESET_VALUE;
		divider_word[apc_pkg::APC_CONV_MSB:apc_pkg::APC_CONV_LSB] = st.conv_prescale;
		divider_word[apc_pkg::APC_PLL_INPUT_PREDIVIDER_MSB:apc_pkg::APC_PLL_INPUT_PREDIVIDER_LSB] = st.predivider;
		source_word = apc_pkg::APC_RESET_VALUE;
		source_word[apc_pkg::APC_TIM_C_BIT] = st.timer_c;
		source_word[apc_pkg::APC_TIM_B_BIT] = st.timer_b;
		source_word[apc_pkg::APC_TIM_A_BIT] = st.timer_a;
		source_word[apc_pkg::APC_TIM_MAIN_BIT] = st.timer_main;
		source_word[apc_pkg::APC_I2C_A_BIT] = st.i2c_a;
		source_word[apc_pkg::APC_I2C_B_BIT] = st.i2c_b;
		source_word[apc_pkg::APC_I2C_C_BIT] = st.i2c_c;
		source_word[apc_pkg::APC_SERIAL_MSB:apc_pkg::APC_SERIAL_LSB] = st.serial;
	end

	always_comb
	begin
		bus.rdata = 32'h0000_0000;
		if (bus.addr == apc_pkg::APC_OFS_DIVIDER)
			bus.rdata = divider_word;
		else if (bus.addr == apc_pkg::APC_OFS_SOURCE)
			bus.rdata = source_word;
	end

	// cumulative ahb plus apb2 division decides whether timer selects may be held
	assign bus_div_log2 = 5'(ahb_divisor_log2) + 5'(apb2_divisor_log2);
	assign timer_group_open = system_core_clock_is_pll && (bus_div_log2 <= apc_pkg::APC_TIM_MAX_DIV_LOG2);
	assign main_timer_open = system_core_clock_is_pll && (bus_div_log2 == 5'h00);

	always_comb
	begin
		byte_mask = {{8{bus.byte_en[3]}}, {8{bus.byte_en[2]}}, {8{bus.byte_en[1]}}, {8{bus.byte_en[0]}}};
		merged = 32'h0000_0000;
		next_st = st;
		if (bus.wr_en && bus.addr == apc_pkg::APC_OFS_DIVIDER)
		begin
			merged = (divider_word & ~byte_mask) | (bus.wdata & byte_mask);
			next_st.conv_prescale = merged[apc_pkg::APC_CONV_MSB:apc_pkg::APC_CONV_LSB];
			// predivider frozen while the pll runs
			if (!pll_enabled)
				next_st.predivider = merged[apc_pkg::APC_PLL_INPUT_PREDIVIDER_MSB:apc_pkg::APC_PLL_INPUT_PREDIVIDER_LSB];
		end
		if (main_cfg_bit17_wr && !pll_enabled)
			next_st.predivider[0] = main_cfg_bit17_wdata;
		if (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE)
		begin
			merged = (source_word & ~byte_mask) | (bus.wdata & byte_mask);
			next_st.i2c_a = merged[apc_pkg::APC_I2C_A_BIT];
			next_st.i2c_b = merged[apc_pkg::APC_I2C_B_BIT];
			next_st.i2c_c = HAS_I2C_PORT_C && merged[apc_pkg::APC_I2C_C_BIT];
			next_st.serial = apc_pkg::apc_serial_src_t'(merged[apc_pkg::APC_SERIAL_MSB:apc_pkg::APC_SERIAL_LSB]);
			if (timer_group_open)
			begin
				next_st.timer_a = merged[apc_pkg::APC_TIM_A_BIT];
				next_st.timer_b = merged[apc_pkg::APC_TIM_B_BIT];
				next_st.timer_c = merged[apc_pkg::APC_TIM_C_BIT];
			end
			if (main_timer_open)
				next_st.timer_main = merged[apc_pkg::APC_TIM_MAIN_BIT];
		end
		// leaving the allowed clock setup drops back to the apb2 source
		if (!timer_group_open)
		begin
			next_st.timer_a = 1'b0;
			next_st.timer_b = 1'b0;
			next_st.timer_c = 1'b0;
		end
		if (!main_timer_open)
			next_st.timer_main = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign converter_clock_enable = st.conv_prescale[4];
	assign converter_divide_ratio = conv_ratio(st.conv_prescale[3:0]);
	assign pll_input_divide_ratio = 5'(st.predivider) + 5'h01;
	assign main_cfg_bit17_rdata = st.predivider[0];

	apc_tick_divider #(.WIDTH(apc_pkg::APC_RATIO_W)) u_conv_div
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.enable   (converter_clock_enable),
		.ratio    (converter_divide_ratio),
		.tick_in  (pll_clock_tick),
		.tick_out (converter_clock_tick)
	);

	apc_tick_divider #(.WIDTH(apc_pkg::APC_RATIO_W)) u_pll_input_predivider
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.enable   (1'b1),
		.ratio    (apc_pkg::APC_RATIO_W'(pll_input_divide_ratio)),
		.tick_in  (external_fast_oscillator_tick),
		.tick_out (pll_reference_tick)
	);

	assign timer_a_clock_from_pll = st.timer_a;
	assign timer_b_clock_from_pll = st.timer_b;
	assign timer_c_clock_from_pll = st.timer_c;
	assign main_timer_clock_from_pll = st.timer_main;
	assign apb2_timer_clock_doubled = (apb2_divisor_log2 != 3'h0);
	assign i2c_port_a_clock_from_system = st.i2c_a;
	assign i2c_port_b_clock_from_system = st.i2c_b;
	assign i2c_port_c_clock_from_system = st.i2c_c;
	assign serial_port_clock_source = st.serial;

	default clocking apc_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_CONV_GATED: assert property (!st.conv_prescale[4] |=> !converter_clock_tick)
		else $error("converter tick while prescale gate is off");
	AST_CONV_DIV6: assert property (st.conv_prescale == 5'h13 |-> converter_divide_ratio == 9'h006)
		else $error("prescale 10011 does not divide by 6");
	AST_CONV_DIV16: assert property (st.conv_prescale == 5'h17 |-> converter_divide_ratio == 9'h010)
		else $error("prescale 10111 does not divide by 16");
	AST_CONV_TOP: assert property (st.conv_prescale[4:3] == 2'b11 && st.conv_prescale[2:0] >= 3'h3
		|-> converter_divide_ratio == 9'h100)
		else $error("top prescale codes do not divide by 256");
	AST_PLL_INPUT_PREDIVIDER_ONE: assert property (st.predivider == 4'h0 |-> pll_input_divide_ratio == 5'h01)
		else $error("predivider 0000 does not pass the oscillator");
	AST_PLL_INPUT_PREDIVIDER_LOCK: assert property (pll_enabled |=> $stable(st.predivider))
		else $error("predivider changed while pll enabled");
	AST_SHARED_BIT: assert property (main_cfg_bit17_wr && !pll_enabled
		|=> main_cfg_bit17_rdata == $past(main_cfg_bit17_wdata) && divider_word[0] == main_cfg_bit17_rdata)
		else $error("shared predivider bit not updated by main register write");
	AST_TIM_GROUP_CLR: assert property (!timer_group_open |=> !timer_a_clock_from_pll && !timer_c_clock_from_pll)
		else $error("timer select kept after its condition ended");
	AST_TIM_MAIN_CLR: assert property (!main_timer_open ##1 !main_timer_open |-> !main_timer_clock_from_pll)
		else $error("main timer select set without undivided pll clock");
	AST_SERIAL_MAP: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && bus.byte_en[0]
		|=> serial_port_clock_source == $past(bus.wdata[1:0]))
		else $error("serial port source does not follow its field");
	AST_NO_WAIT: assert property (hreadyout && !hresp)
		else $error("slave inserted a wait state or error");

	AST_CONV_DIV1: assert property (st.conv_prescale == 5'h10 |-> converter_divide_ratio == 9'h001)
		else $error("prescale 10000 does not divide by 1");

	AST_CONV_DIV2: assert property (st.conv_prescale == 5'h11 |-> converter_divide_ratio == 9'h002)
		else $error("prescale 10001 does not divide by 2");

	AST_CONV_DIV4: assert property (st.conv_prescale == 5'h12 |-> converter_divide_ratio == 9'h004)
		else $error("prescale 10010 does not divide by 4");

	AST_CONV_DIV8: assert property (st.conv_prescale == 5'h14 |-> converter_divide_ratio == 9'h008)
		else $error("prescale 10100 does not divide by 8");

	AST_CONV_DIV10: assert property (st.conv_prescale == 5'h15 |-> converter_divide_ratio == 9'h00a)
		else $error("prescale 10101 does not divide by 10");

	AST_CONV_DIV12: assert property (st.conv_prescale == 5'h16 |-> converter_divide_ratio == 9'h00c)
		else $error("prescale 10110 does not divide by 12");

	AST_CONV_DIV32: assert property (st.conv_prescale == 5'h18 |-> converter_divide_ratio == 9'h020)
		else $error("prescale 11000 does not divide by 32");

	AST_CONV_DIV64: assert property (st.conv_prescale == 5'h19 |-> converter_divide_ratio == 9'h040)
		else $error("prescale 11001 does not divide by 64");

	AST_CONV_DIV128: assert property (st.conv_prescale == 5'h1a |-> converter_divide_ratio == 9'h080)
		else $error("prescale 11010 does not divide by 128");

	AST_CONV_ENABLE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_DIVIDER && bus.byte_en[1]
		|=> converter_clock_enable == $past(bus.wdata[8]))
		else $error("converter enable does not follow the prescale top bit");

	AST_CONV_PASS: assert property (converter_clock_enable && converter_divide_ratio == 9'h001 && pll_clock_tick
		|=> converter_clock_tick)
		else $error("ratio one does not pass a pll tick");

	AST_PLL_INPUT_PREDIVIDER_FOUR: assert property (st.predivider == 4'h3 |-> pll_input_divide_ratio == 5'h04)
		else $error("predivider 0011 does not divide by 4");

	AST_PLL_INPUT_PREDIVIDER_SIXTEEN: assert property (st.predivider == 4'hf |-> pll_input_divide_ratio == 5'h10)
		else $error("predivider 1111 does not divide by 16");

	AST_PLL_INPUT_PREDIVIDER_PASS: assert property (pll_input_divide_ratio == 5'h01 && external_fast_oscillator_tick
		|=> pll_reference_tick)
		else $error("undivided predivider does not pass an oscillator tick");

	AST_PLL_INPUT_PREDIVIDER_WRITE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_DIVIDER && bus.byte_en[0]
		&& !pll_enabled && !main_cfg_bit17_wr |=> st.predivider == $past(bus.wdata[3:0]))
		else $error("predivider write with pll off did not land");

	AST_READ_DIVIDER: assert property (bus.rd_en && bus.addr == apc_pkg::APC_OFS_DIVIDER
		|-> hrdata[31:9] == 23'h00_0000 && pll_input_divide_ratio == 5'(hrdata[3:0]) + 5'h01)
		else $error("divider read does not match the predivider ratio");

	AST_SHARED_VIEW: assert property (bus.rd_en && bus.addr == apc_pkg::APC_OFS_DIVIDER
		|-> hrdata[0] == main_cfg_bit17_rdata)
		else $error("shared bit differs between the two views");

	AST_TIM_GROUP_WRITE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && bus.byte_en[1]
		&& timer_group_open |=> timer_c_clock_from_pll == $past(bus.wdata[13]))
		else $error("open timer group select did not take the write");

	AST_TIM_GROUP_REFUSE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && !timer_group_open
		|=> !timer_b_clock_from_pll)
		else $error("closed timer group select took a write");

	AST_TIM_MAIN_WRITE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && bus.byte_en[1]
		&& main_timer_open |=> main_timer_clock_from_pll == $past(bus.wdata[8]))
		else $error("open main timer select did not take the write");

	AST_TIM_MAIN_REFUSE: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && !main_timer_open
		|=> !main_timer_clock_from_pll)
		else $error("closed main timer select took a write");

	AST_APB2_DOUBLE: assert property (apb2_divisor_log2 == 3'h0 |-> !apb2_timer_clock_doubled)
		else $error("undivided apb2 clock reported as doubled");

	AST_I2C_MAP: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && bus.byte_en[0]
		|=> i2c_port_a_clock_from_system == $past(bus.wdata[4])
		&& i2c_port_b_clock_from_system == $past(bus.wdata[5]))
		else $error("i2c source selects do not follow their bits");

	AST_I2C_C_MAP: assert property (bus.wr_en && bus.addr == apc_pkg::APC_OFS_SOURCE && bus.byte_en[0]
		|=> i2c_port_c_clock_from_system == (HAS_I2C_PORT_C && $past(bus.wdata[6])))
		else $error("third i2c source select does not follow its bit");

	AST_READ_IDLE: assert property (!bus.rd_en |-> hrdata == 32'h0000_0000)
		else $error("read data driven outside a read data phase");

	AST_READ_SOURCE: assert property (bus.rd_en && bus.addr == apc_pkg::APC_OFS_SOURCE
		|-> hrdata[13] == timer_c_clock_from_pll && hrdata[8] == main_timer_clock_from_pll
		&& hrdata[1:0] == serial_port_clock_source)
		else $error("source select read does not match the selects");

	AST_READ_RESERVED: assert property (bus.rd_en |-> hrdata[31:14] == 18'h0_0000)
		else $error("reserved bits read as nonzero");

	COV_CONV_RUN: cover property (converter_clock_enable ##1 converter_clock_tick);
	COV_TIM_SET: cover property (!main_timer_clock_from_pll ##1 main_timer_clock_from_pll);
	COV_TIM_DROP: cover property (timer_b_clock_from_pll ##1 !timer_b_clock_from_pll);
	COV_SHARED: cover property (main_cfg_bit17_wr && !pll_enabled);
	COV_PLL_INPUT_PREDIVIDER_LOCKED: cover property (pll_enabled && bus.wr_en && bus.addr == apc_pkg::APC_OFS_DIVIDER);
endmodule
`default_nettype wire

// ### verification/tb_adc_pll_divider_and_clock_select.sv
// self-checking bench for the converter prescale and clock source select registers
`timescale 1ns/10ps
`default_nettype none
module tb_adc_pll_divider_and_clock_select;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd_q;
	logic        pll_on;
	logic        sys_pll;
	logic [3:0]  ahb_l2;
	logic [2:0]  apb_l2;
	logic        b17_wr;
	logic        b17_wd;
	logic        b17_rd;
	logic        pll_tick;
	logic        osc_tick;
	logic        conv_en;
	logic [8:0]  conv_ratio;
	logic [4:0]  pre_ratio;
	logic [1:0]  ticks;
	logic [3:0]  tim;
	logic        doubled;
	logic [2:0]  i2c;
	logic [1:0]  serial;
	logic [31:0] v;
	int          err_count;
	int          n_compared;
	int          cycles;
	logic [8:0]  div_tab [16] = '{9'h001, 9'h002, 9'h004, 9'h006, 9'h008, 9'h00a, 9'h00c, 9'h010,
		9'h020, 9'h040, 9'h080, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100};

	apc_clock_config i_apc_clock_config (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .pll_enabled(pll_on), .system_core_clock_is_pll(sys_pll),
		.ahb_divisor_log2(ahb_l2), .apb2_divisor_log2(apb_l2), .main_cfg_bit17_wr(b17_wr),
		.main_cfg_bit17_wdata(b17_wd), .main_cfg_bit17_rdata(b17_rd), .pll_clock_tick(pll_tick),
		.external_fast_oscillator_tick(osc_tick), .converter_clock_enable(conv_en),
		.converter_divide_ratio(conv_ratio), .converter_clock_tick(ticks[0]),
		.pll_input_divide_ratio(pre_ratio), .pll_reference_tick(ticks[1]), .timer_a_clock_from_pll(tim[0]),
		.timer_b_clock_from_pll(tim[1]), .timer_c_clock_from_pll(tim[2]), .main_timer_clock_from_pll(tim[3]),
		.apb2_timer_clock_doubled(doubled), .i2c_port_a_clock_from_system(i2c[0]),
		.i2c_port_b_clock_from_system(i2c[1]), .i2c_port_c_clock_from_system(i2c[2]),
		.serial_port_clock_source(serial));

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// read data is captured at the edge that ends the data phase
	always @(posedge hclk)
		rd_q <= hrdata;

	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			$display("wrong value timeout expected 0 seen %0d cycles", cycles);
			summarize();
		end
	end

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic wr, input logic [2:0] sz, input logic [31:0] wd);
		int waits;
		waits = 0;
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= sz;
		@(posedge hclk);
		while (hready !== 1'b1 && waits < 50)
		begin
			@(posedge hclk);
			waits++;
		end
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1 && waits < 50)
		begin
			@(posedge hclk);
			waits++;
		end
		#1;
		v = rd_q;
		check("wait states", 32'h0, waits);
		check("response", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, 3'h2, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(a, 1'b0, 3'h2, 32'h0);
		check(name, exp, v);
	endtask

	task automatic status(input logic pll, input logic [3:0] ahb, input logic [2:0] apb);
		@(posedge hclk);
		sys_pll <= pll;
		ahb_l2  <= ahb;
		apb_l2  <= apb;
		repeat (2) @(posedge hclk);
		#1;
	endtask

	// spacing in cycles between two output ticks while the source ticks every cycle
	task automatic period(input int sel, input logic [8:0] exp, input string name);
		int n;
		n = 0;
		while (ticks[sel] !== 1'b1 && n < 600)
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		n = 0;
		do
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		while (ticks[sel] !== 1'b1 && n < 600);
		check(name, {23'h0, exp}, n);
	endtask

	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, pll_on, sys_pll} = '0;
		{ahb_l2, apb_l2, b17_wr, b17_wd, pll_tick, osc_tick, err_count, n_compared} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		pll_tick <= 1'b1;
		osc_tick <= 1'b1;
		rd(8'h2c, 32'h0, "divider reset");
		rd(8'h30, 32'h0, "source reset");
		check("pre ratio reset", 32'h1, {27'h0, pre_ratio});
		for (int i = 0; i < 32; i++)
		begin
			wr(8'h2c, i << 4);
			check("conv enable", {31'h0, i[4]}, {31'h0, conv_en});
			if (i[4])
				check("conv ratio", {23'h0, div_tab[i[3:0]]}, {23'h0, conv_ratio});
			if (i == 16 || i == 19 || i == 31)
				period(0, div_tab[i[3:0]], "conv period");
		end
		wr(8'h2c, 32'h0000_00f0);
		repeat (20) @(posedge hclk);
		for (int n = 0; n < 20; n++)
		begin
			@(posedge hclk);
			#1;
			check("gated conv tick", 32'h0, {31'h0, ticks[0]});
		end
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h2c, i);
			rd(8'h2c, i, "predivider");
			check("pre ratio", i + 1, {27'h0, pre_ratio});
			if (i == 0 || i == 3 || i == 15)
				period(1, 9'(i + 1), "pre period");
		end
		wr(8'h2c, 32'h0000_0002);
		@(posedge hclk);
		b17_wr <= 1'b1;
		b17_wd <= 1'b1;
		@(posedge hclk);
		b17_wr <= 1'b0;
		rd(8'h2c, 32'h0000_0003, "shared bit set");
		check("bit17 read", 32'h1, {31'h0, b17_rd});
		@(posedge hclk);
		pll_on <= 1'b1;
		wr(8'h2c, 32'h0000_0118);
		rd(8'h2c, 32'h0000_0113, "predivider locked");
		@(posedge hclk);
		pll_on <= 1'b0;
		wr(8'h2c, 32'h0000_00a4);
		check("bit17 cleared", 32'h0, {31'h0, b17_rd});
		bus(8'h2d, 1'b1, 3'h0, 32'h0000_0100);
		rd(8'h2c, 32'h0000_01a4, "byte lane write");
		wr(8'h34, 32'hffff_ffff);
		rd(8'h34, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++)
		begin
			bus(8'h30, 1'b1, 3'h1, (((i * 3) % 8) << 4) | i);
			rd(8'h30, (((i * 3) % 8) << 4) | i, "i2c serial");
			check("serial src", i, {30'h0, serial});
			check("i2c src", (i * 3) % 8, {29'h0, i2c});
		end
		wr(8'h30, 32'h0000_2d00);
		rd(8'h30, 32'h0, "timers closed");
		status(1'b1, 4'h1, 3'h0);
		wr(8'h30, 32'h0000_2d00);
		rd(8'h30, 32'h0000_2c00, "timers div two");
		check("timer sources", 32'h7, {28'h0, tim});
		status(1'b1, 4'h0, 3'h0);
		wr(8'h30, 32'h0000_2d00);
		rd(8'h30, 32'h0000_2d00, "timers undivided");
		check("apb2 doubled", 32'h0, {31'h0, doubled});
		status(1'b1, 4'h0, 3'h1);
		rd(8'h30, 32'h0000_2c00, "main timer cleared");
		check("apb2 doubled", 32'h1, {31'h0, doubled});
		status(1'b1, 4'h1, 3'h1);
		rd(8'h30, 32'h0, "timers cleared");
		check("timer sources", 32'h0, {28'h0, tim});
		// software sets the selects again once the condition is back
		status(1'b1, 4'h0, 3'h0);
		wr(8'h30, 32'h0000_2d73);
		status(1'b0, 4'h0, 3'h0);
		rd(8'h30, 32'h0000_0073, "system_core_clock leaves pll");
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h2c, 32'h0, "divider rereset");
		rd(8'h30, 32'h0, "source rereset");
		summarize();
	end
endmodule
`default_nettype wire
